// >>> hw/pfcr_rx.sv
// top of the parallel forward channel receiver with its byte buffer
`timescale 1ns/1ps
module pfcr_rx
    import pfcr_pkg::*;
#(
    parameter int BUF_BYTES = PFCR_BUF_BYTES,   // buffer depth in bytes
    parameter int INIT_CYC = PFCR_INIT_CYC,     // cycles of init low that count as held
    parameter int HWINIT_CYC = PFCR_HWINIT_CYC  // cycles of local initialisation
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // host side pins
    input wire logic strobe_n_i,
    input wire logic [PFCR_DATA_W-1:0] data_i,
    input wire logic init_n_i,
    input wire logic auto_feed_input_n_i,
    input wire logic select_in_input_n_i,
    // printer conditions
    input wire pfcr_cond_t cond_i,
    // printer side drain
    input wire logic rd_ready_i,
    output logic rd_valid_o,
    output logic [PFCR_DATA_W-1:0] rd_data_o,
    // status pins to host
    output pfcr_status_t status_o,
    output logic init_busy_o
);

    localparam int AW = $clog2(BUF_BYTES);

    // elaboration checks
    initial begin
        if (BUF_BYTES < 2 || (BUF_BYTES & (BUF_BYTES - 1)) != 0) begin
            $error("BUF_BYTES must be a power of two of at least 2");
        end
        if (INIT_CYC < 1 || INIT_CYC >= 2 ** PFCR_CNT_W || HWINIT_CYC < 1
                || HWINIT_CYC >= 2 ** PFCR_CNT_W) begin
            $error("init counts out of range");
        end
    end

    // ************************************************************
    // strobe edge and init detection
    // ************************************************************
    logic strobe_d;                          // strobe one cycle ago
    logic init_d;                            // init one cycle ago
    logic [PFCR_CNT_W-1:0] init_low_cnt;     // length of current init low
    logic [PFCR_CNT_W-1:0] hwinit_cnt;       // remaining local init cycles
    logic [PFCR_DATA_W-1:0] byte_latch;      // byte caught at strobe fall

    // levels on the unused control inputs never reach the handshake
    wire unused_ctl = auto_feed_input_n_i & select_in_input_n_i;

    wire strobe_fall = strobe_d & ~strobe_n_i;
    wire init_fall = init_d & ~init_n_i;
    wire init_held = ~init_n_i && (init_low_cnt == PFCR_CNT_W'(INIT_CYC));
    wire init_start = init_fall | init_held;
    wire hwinit_run = (hwinit_cnt != '0);

    // edge history registers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strobe_d <= 1'b1;
            init_d <= 1'b1;
        end else begin
            strobe_d <= strobe_n_i;
            init_d <= init_n_i;
        end
    end

    // count how long init has been low; saturates at the threshold
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            init_low_cnt <= '0;
        end else if (init_n_i) begin
            init_low_cnt <= '0;
        end else if (init_low_cnt != PFCR_CNT_W'(INIT_CYC)) begin
            init_low_cnt <= init_low_cnt + 1'b1;
        end
    end

    // local initialisation timer, restarted by each init request
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hwinit_cnt <= PFCR_CNT_W'(HWINIT_CYC);
        end else if (init_start) begin
            hwinit_cnt <= PFCR_CNT_W'(HWINIT_CYC);
        end else if (hwinit_run) begin
            hwinit_cnt <= hwinit_cnt - 1'b1;
        end
    end

    // ************************************************************
    // byte buffer
    // ************************************************************
    logic [PFCR_DATA_W-1:0] mem [BUF_BYTES];  // byte storage
    logic [AW:0] wr_ptr;                      // write pointer with wrap bit
    logic [AW:0] rd_ptr;                      // read pointer with wrap bit
    logic [PFCR_DATA_W-1:0] rd_word;          // registered read word

    wire buf_empty = (wr_ptr == rd_ptr);
    wire buf_full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire flush = init_start | hwinit_run;     // initialisation drops stored data
    pfcr_state_t state;
    pfcr_state_t next_state;
    wire wr_en = (state == PFCR_STORE) && !buf_full && !flush;
    // output word is free to be refilled when nothing or a taken word sits there
    wire rd_load = !buf_empty && (!rd_valid_o || rd_ready_i) && !flush;

    // storage write; no reset so it maps to block memory
    always_ff @(posedge sys_clk_i) begin
        if (wr_en) begin
            mem[wr_ptr[AW-1:0]] <= byte_latch;
        end
        if (rd_load) begin
            rd_word <= mem[rd_ptr[AW-1:0]];
        end
    end

    // pointers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (wr_en) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (rd_load) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // output valid flag
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_valid_o <= 1'b0;
        end else if (flush) begin
            rd_valid_o <= 1'b0;
        end else if (rd_load) begin
            rd_valid_o <= 1'b1;
        end else if (rd_ready_i) begin
            rd_valid_o <= 1'b0;
        end
    end

    assign rd_data_o = rd_word;

    // ************************************************************
    // handshake sequencer
    // ************************************************************
    logic [PFCR_CNT_W-1:0] ack_cnt;            // ack pulse cycles left

    wire err_any = cond_i.fatal_err | cond_i.paper_out | cond_i.paper_jam
                   | cond_i.ink_out;
    wire hold_busy = ~init_n_i | hwinit_run | err_any | cond_i.test_print
                     | cond_i.setup_mode | ~cond_i.port_selected | buf_full;
    // error pins move only once busy already stands high
    wire err_show = err_any & status_o.busy;

    // next state decode
    always_comb begin
        next_state = state;
        case (state)
            PFCR_IDLE: begin
                if (strobe_fall && !flush) begin
                    next_state = PFCR_STORE;
                end
            end
            PFCR_STORE: begin
                if (flush) begin
                    next_state = PFCR_IDLE;
                end else if (!buf_full) begin
                    next_state = PFCR_WAIT;
                end
            end
            PFCR_WAIT: begin
                if (!hold_busy && !unused_ctl && 1'b0) begin
                    next_state = PFCR_ACK;     // never taken; ignored inputs
                end else if (!hold_busy) begin
                    next_state = PFCR_ACK;
                end
            end
            PFCR_ACK: begin
                if (ack_cnt == PFCR_CNT_W'(1)) begin
                    next_state = PFCR_IDLE;
                end
            end
            default: next_state = PFCR_IDLE;
        endcase
    end

    // state, latch and ack timer
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= PFCR_IDLE;
            byte_latch <= '0;
            ack_cnt <= '0;
        end else begin
            state <= next_state;
            if (state == PFCR_IDLE && strobe_fall) begin
                byte_latch <= data_i;
            end
            if (next_state == PFCR_ACK && state != PFCR_ACK) begin
                ack_cnt <= PFCR_CNT_W'(PFCR_ACK_CYC);
            end else if (ack_cnt != '0) begin
                ack_cnt <= ack_cnt - 1'b1;
            end
        end
    end

    // ************************************************************
    // registered status pins
    // ************************************************************
    wire next_busy = (next_state != PFCR_IDLE && next_state != PFCR_ACK)
                     || (next_state == PFCR_IDLE && strobe_fall)
                     || hold_busy;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_o <= '{busy: 1'b1, byte_accept_pulse_n: 1'b1,
                          paper_empty_flag: 1'b0, online_indicator: 1'b1, fault_n: 1'b1};
            init_busy_o <= 1'b1;
        end else begin
            status_o.busy <= next_busy | err_any;
            status_o.byte_accept_pulse_n <= (next_state != PFCR_ACK);
            status_o.paper_empty_flag <= err_show & cond_i.paper_out;
            status_o.online_indicator <= 1'b1;
            status_o.fault_n <= ~err_show;
            init_busy_o <= flush;
        end
    end

endmodule

// >>> hw/pfcr_pkg.sv
// package for the parallel forward channel receiver: constants, states and carriers
// ****************************************************************************
// Overview of operation
// - one 8-bit byte per host strobe
// - latch data at strobe falling edge
// - data line n is bit n, high is one
// - low pulse on byte accept when ready again
// - busy high means host must not strobe
// - busy rises before fault or paper empty
// - busy during byte intake or full buffer
// - busy during init, hardware init, errors
// - busy during test print, setup, deselect
// - fault low on fatal, paper, jam, ink
// - paper empty high during paper-out
// - online indicator always high when powered
// - init on init falling edge or low
// - 64 kilobyte input buffer, busy when full
// ****************************************************************************
package pfcr_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int PFCR_CLK_HZ = 40_000_000;          // system clock rate
    localparam int PFCR_CLK_PERIOD_NS = 25;           // period of sys_clk_i
    localparam int PFCR_ACK_NS = 1000;                // ack pulse width, fast rate
    localparam int PFCR_ACK_CYC = (PFCR_ACK_NS + PFCR_CLK_PERIOD_NS - 1) / PFCR_CLK_PERIOD_NS;
    localparam int PFCR_INIT_US = 50;                 // host init pulse least width
    localparam int PFCR_INIT_CYC = PFCR_INIT_US * (PFCR_CLK_HZ / 1_000_000);
    localparam int PFCR_HWINIT_CYC = 64;              // local initialisation length
    localparam int PFCR_CNT_W = 16;                   // width of timing counters

    // ************************************************************
    // buffer
    // ************************************************************
    localparam int PFCR_BUF_BYTES = 65536;            // 64 kilobytes
    localparam int PFCR_DATA_W = 8;                   // byte width

    // ************************************************************
    // handshake states
    // ************************************************************
    typedef enum logic [1:0] {
        PFCR_IDLE  = 2'b00,   // waiting for strobe
        PFCR_STORE = 2'b01,   // byte being written
        PFCR_WAIT  = 2'b10,   // waiting for space / ready
        PFCR_ACK   = 2'b11    // ack pulse low
    } pfcr_state_t;

    // printer condition inputs
    typedef struct packed {
        logic fatal_err;      // hardware fatal error
        logic paper_out;      // paper-out error
        logic paper_jam;      // paper-jam error
        logic ink_out;        // ink-out error
        logic test_print;     // test printing running
        logic setup_mode;     // default setting mode
        logic port_selected;  // parallel interface is the selected input
    } pfcr_cond_t;

    // status pins driven to the host
    typedef struct packed {
        logic busy;
        logic byte_accept_pulse_n;
        logic paper_empty_flag;
        logic online_indicator;
        logic fault_n;
    } pfcr_status_t;

endpackage

// >>> dv/pfcr_rx_assertions.sv
// port checker for the parallel forward channel receiver
`timescale 1ns/1ps
module pfcr_rx_assertions
    import pfcr_pkg::*;
#(
    parameter int BUF_BYTES = 16,
    parameter int INIT_CYC = 8,
    parameter int HWINIT_CYC = 4
) (
    // watched ports
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic strobe_n_i,
    input wire logic init_n_i,
    input wire pfcr_cond_t cond_i,
    input wire pfcr_status_t status_o
);
    logic [7:0] low_cnt; // cycles the accept pulse has stood low
    logic err; // any error that pulls the fault line
    assign err = cond_i.fatal_err | cond_i.paper_out | cond_i.paper_jam | cond_i.ink_out;
    // counter, since a 40 cycle repetition would be too costly to unroll
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= status_o.byte_accept_pulse_n ? 8'h00 : low_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // a strobe the receiver is free to take
    sequence s_take;
        $fell(strobe_n_i) && !status_o.busy && status_o.byte_accept_pulse_n && init_n_i;
    endsequence
    sequence s_flag_set;
        $fell(status_o.fault_n) || $rose(status_o.paper_empty_flag);
    endsequence
    a_take_busy: assert property (s_take |=> status_o.busy)
        else $error("busy late after strobe");
    a_ack_width: assert property ($rose(status_o.byte_accept_pulse_n) |-> low_cnt == PFCR_ACK_CYC)
        else $error("accept pulse width wrong");
    a_ack_after_busy: assert property ($fell(status_o.byte_accept_pulse_n) |-> $past(status_o.busy))
        else $error("accept pulse without busy");
    a_flag_order: assert property (s_flag_set |-> $past(status_o.busy))
        else $error("flag before busy");
    a_flag_hold: assert property (!status_o.fault_n || status_o.paper_empty_flag |-> status_o.busy)
        else $error("busy low with flag active");
    a_fault_err: assert property (err [*4] |-> !status_o.fault_n)
        else $error("fault line not low on error");
    a_paper_flag: assert property (cond_i.paper_out [*4] |-> status_o.paper_empty_flag)
        else $error("paper empty flag missing");
    a_online_high: assert property (status_o.online_indicator)
        else $error("online indicator low");
    a_init_busy: assert property (!init_n_i [*2] |-> status_o.busy)
        else $error("busy low during init");
    a_mode_busy: assert property ((!cond_i.port_selected || cond_i.test_print
        || cond_i.setup_mode) [*2] |-> status_o.busy)
        else $error("busy low while deselected");
endmodule

// >>> dv/pfcr_host_model.sv
// host port model driving strobe and data
`timescale 1ns/1ps
module pfcr_host_model #(
    parameter int T = 20 // setup and hold, in cycles
) (
    // clock and printer status
    input wire logic sys_clk_i,
    input wire logic busy_i,
    input wire logic ack_n_i,
    // host pins
    output logic strobe_n_o,
    output logic [7:0] data_o
);
    initial begin
        strobe_n_o = 1'b1;
        data_o = 8'h00;
    end
    // one byte per strobe; w sets a prompt or a slow strobe
    task automatic send(input logic [7:0] b, input int w);
        // look at busy off the edge that launches it, never in that same time step
        while (busy_i !== 1'b0 || ack_n_i !== 1'b1) begin
            @(posedge sys_clk_i);
            #2;
        end
        data_o = b;
        repeat (T) @(posedge sys_clk_i);
        #2 strobe_n_o = 1'b0;
        repeat (w) @(posedge sys_clk_i);
        #2 strobe_n_o = 1'b1;
        repeat (T) @(posedge sys_clk_i);
        #2 data_o = ~b; // released lines show no stale byte
    endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the forward channel receiver
`timescale 1ns/1ps
module testbench
    import pfcr_pkg::*;
;
    // ****************************************
    // signals and byte table
    // ****************************************
    logic sys_clk, resetn, strobe_n, init_n, afd_n, sin_n, rd_ready, rd_valid, init_busy;
    logic [7:0] data, rd_data;
    pfcr_cond_t cond;
    pfcr_status_t st;
    int n_fail = 0;
    int checks = 0;
    logic [7:0] exp_q[$]; // bytes owed to the drain
    // host byte beside the byte the drain should see
    logic [15:0] rows [6] = '{16'h0000, 16'hffff, 16'ha5a5, 16'h5a5a, 16'h0101, 16'h8080};
    pfcr_rx #(.BUF_BYTES(16), .INIT_CYC(8), .HWINIT_CYC(4)) u_dut (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .strobe_n_i(strobe_n), .data_i(data),
        .init_n_i(init_n), .auto_feed_input_n_i(afd_n), .select_in_input_n_i(sin_n),
        .cond_i(cond), .rd_ready_i(rd_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
        .status_o(st), .init_busy_o(init_busy));
    pfcr_host_model u_host (.sys_clk_i(sys_clk), .busy_i(st.busy),
        .ack_n_i(st.byte_accept_pulse_n), .strobe_n_o(strobe_n), .data_o(data));
    // ****************************************
    // tasks
    // ****************************************
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic put(input logic [7:0] b, input logic [7:0] e, input int w);
        exp_q.push_back(e);
        u_host.send(b, w);
    endtask
    // drain all owed bytes, sampled mid-cycle so the edge cannot race
    task automatic drain;
        int g;
        g = 0;
        rd_ready = 1'b1;
        while (exp_q.size() > 0 && g < 3000) begin
            @(negedge sys_clk);
            g++;
            if (rd_valid === 1'b1) cmp_byte("rd_data", exp_q.pop_front(), rd_data);
        end
        cmp_bit("drained", 1'b1, exp_q.size() == 0);
        @(posedge sys_clk);
        #2 rd_ready = 1'b0;
    endtask
    // clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        complete_run();
    end
    initial begin
        resetn = 1'b0;
        init_n = 1'b1;
        afd_n = 1'b1;
        sin_n = 1'b1;
        rd_ready = 1'b0;
        cond = 7'h01;
        cyc(3);
        cmp_bit("busy", 1'b1, st.busy);
        cmp_bit("ack_n", 1'b1, st.byte_accept_pulse_n);
        cmp_bit("online", 1'b1, st.online_indicator);
        resetn = 1'b1;
        foreach (rows[i]) begin
            afd_n = i[0];
            sin_n = i[1];
            put(rows[i][15:8], rows[i][7:0], 20);
        end
        drain();
        // fill the buffer with the drain stalled; one byte sits in the output word,
        // so it takes one byte more than the depth before busy stays up
        for (int i = 0; i < 17; i++) put(8'(i * 17), 8'(i * 17), 20);
        cyc(50);
        cmp_bit("busy_full", 1'b1, st.busy);
        drain();
        cyc(50);
        cmp_bit("busy_free", 1'b0, st.busy);
        // each printer condition in turn, the last one deselects the port
        for (int i = 0; i < 7; i++) begin
            cond = (i == 6) ? 7'h00 : (7'h01 | (7'h40 >> i));
            cyc(6);
            cmp_bit("busy_cond", 1'b1, st.busy);
            cmp_bit("fault_n", i > 3, st.fault_n);
            cmp_bit("paper_empty", i == 1, st.paper_empty_flag);
            cond = 7'h01;
            cyc(6);
            cmp_bit("busy_clear", 1'b0, st.busy);
        end
        // init held past the host minimum: the edge starts it, the level keeps it going
        put(8'h3c, 8'h3c, 20);
        init_n = 1'b0;
        cyc(2);
        cmp_bit("init_edge", 1'b1, init_busy);
        cyc(20);
        cmp_bit("init_held", 1'b1, init_busy);
        cmp_bit("busy_init", 1'b1, st.busy);
        cyc(PFCR_INIT_CYC);
        init_n = 1'b1;
        cyc(30);
        cmp_bit("flushed", 1'b0, rd_valid);
        cmp_bit("init_done", 1'b0, init_busy);
        exp_q.delete();
        // a second minimum-width pulse; local init still runs just after release
        init_n = 1'b0;
        cyc(PFCR_INIT_CYC);
        init_n = 1'b1;
        cyc(1);
        cmp_bit("init_tail", 1'b1, init_busy);
        put(8'hc3, 8'hc3, 60);
        drain();
        complete_run();
    end
endmodule
bind pfcr_rx pfcr_rx_assertions #(.BUF_BYTES(BUF_BYTES), .INIT_CYC(INIT_CYC),
    .HWINIT_CYC(HWINIT_CYC)) u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .strobe_n_i(strobe_n_i), .init_n_i(init_n_i), .cond_i(cond_i), .status_o(status_o));
